// ==== include/qd_params.svh ====
`ifndef QD_PARAMS_SVH
`define QD_PARAMS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define QD_FRAME_BITS 32
`define QD_LAST_BIT_CNT 6'h1F
`define QD_FULL_CNT 6'h20
`define QD_CMD_MSB 27
`define QD_CMD_LSB 24
`define QD_ADDR_MSB 23
`define QD_ADDR_LSB 20
`define QD_DATA_MSB 19
`define QD_DATA_LSB 4
`define QD_PD_MSB 9
`define QD_PD_LSB 8
`define QD_SEL_MSB 3
`define QD_SEL_LSB 0
`define QD_LOW2_MSB 1
`define QD_LOW2_LSB 0

// ----------------------------------------------------------------------
// Command and address codes
// ----------------------------------------------------------------------
`define QD_CMD_WR_IN 4'h0
`define QD_CMD_UPD 4'h1
`define QD_CMD_WR_UPD_ALL 4'h2
`define QD_CMD_WR_UPD 4'h3
`define QD_CMD_POWER 4'h4
`define QD_CMD_CLR_CODE 4'h5
`define QD_CMD_LOAD_DAC_N_MASK 4'h6
`define QD_CMD_RESET 4'h7
`define QD_CMD_DAISY 4'h8
`define QD_CMD_AUX 4'h9
`define QD_CMD_RSVD 4'hF
`define QD_ADDR_A 4'h0
`define QD_ADDR_B 4'h1
`define QD_ADDR_ALL 4'hF

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define QD_CODE_ZERO 16'h0000
`define QD_CODE_MID 16'h8000
`define QD_CODE_FULL 16'hFFFF
`define QD_PM_NORMAL 2'h0
`define QD_DAISY_CHAIN_ENABLE_RST 2'h0
`define QD_CLR_CODE_RST 2'h0
`define QD_LOAD_DAC_N_MASK_RST 4'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define QD_CLK_PERIOD_NS 25
`define QD_PWRUP_TIME_NS 2500
`define QD_PWRUP_CYCLES ((`QD_PWRUP_TIME_NS + `QD_CLK_PERIOD_NS - 1) / `QD_CLK_PERIOD_NS)
`define QD_POR_WAIT_CYCLES 2'h3

`endif

// ==== include/qd_pkg.sv ====
package qd_pkg;

  typedef enum logic [0:0] {
    QD_ST_POR,
    QD_ST_RUN
  } qd_state_type;

  typedef logic [3:0][15:0] qd_codes_type;

  typedef struct packed {
    logic [5:0] cnt;
    logic [31:0] shift;
    logic done;
  } qd_link_type;

  typedef struct packed {
    qd_state_type state;
    logic [1:0] por_cnt;
    qd_codes_type in_reg;
    qd_codes_type dac_reg;
    logic [3:0][1:0] pmode;
    logic [3:0][6:0] pu_cnt;
    logic [1:0] daisy_chain_enable;
    logic [1:0] clr_code;
    logic [3:0] load_dac_n_mask;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic load_dac_n_s1;
    logic load_dac_n_s2;
    logic load_dac_n_s3;
    logic clr_s1;
    logic clr_s2;
    logic clr_s3;
    logic por_s1;
    logic por_s2;
  } qd_core_type;

endpackage

// ==== core/qd_command_port.sv ====
// Overview of operation
// - Frame-sync low starts frame; shift on falling edges
// - Execute command at 32nd falling edge
// - Layout: ignored, command, address, then data
// - Sixteen-bit code follows address, four ignored
// - Commands 0-3 write, update, write-all, write-update
// - Commands 4-9 decoded; 1111 reserved
// - Address A, B or all; others reserved
// - Early frame-sync rise clears and discards frame
// - Power-on level holds until valid frame
// - Software reset restores power-on code
// - Load and clear pins ignored during reset
// - Power mode from two bits to selected channels
// - Low four bits select channels D..A
// - Powered-down channel output is disconnected
// - Power-down keeps stored DAC contents
// - Not ready for 2.5 us after power-up
// - Power-up resumes from input or held code
// - Daisy-chain setting from two lowest bits
// - Codes are unsigned straight binary
// - Mode encoding: normal, 1k, 100k, high-Z
`include "qd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module qd_command_port #(
  parameter int PWRUP_CYCLES = `QD_PWRUP_CYCLES
) (
  input wire logic clk_i,                       // System clock, 40 MHz
  input wire logic rstn_i,                      // Reset, active low; synchronous in core, asynchronous clear on link side
  input wire logic sclk_i,                      // Serial clock from host
  input wire logic sync_n_i,                    // Frame-sync, active low
  input wire logic din_i,                       // Serial data, sclk domain
  input wire logic load_dac_n_i,                // Load-DAC pin, active low
  input wire logic clear_n_i,                   // Clear pin, falling edge
  input wire logic por_level_i,                 // Power-on level select pin
  output logic [63:0] dac_code_o,               // DAC registers, D..A
  output logic [7:0] power_mode_o,              // Power mode per channel, D..A
  output logic [3:0] out_connected_o,           // Output tied to converter
  output logic [3:0] out_ready_o,               // Output valid, per channel
  output logic [1:0] daisy_chain_enable_o,      // Daisy-chain setting
  output logic por_busy_o                       // Power-on reset in progress
);
  import qd_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [3:0] chan_mask(input logic [3:0] addr);
    logic [3:0] m;
    m = 4'h0;
    unique case (addr)
      `QD_ADDR_A: m = 4'h1;
      `QD_ADDR_B: m = 4'h2;
      `QD_ADDR_ALL: m = 4'hF;
      default: m = 4'h0;
    endcase
    return m;
  endfunction

  function automatic logic [15:0] por_code(input logic level);
    return level ? `QD_CODE_MID : `QD_CODE_ZERO;
  endfunction

  function automatic logic [15:0] clr_value(input logic [1:0] code);
    logic [15:0] v;
    v = `QD_CODE_ZERO;
    unique case (code)
      2'h1: v = `QD_CODE_MID;
      2'h2: v = `QD_CODE_FULL;
      default: v = `QD_CODE_ZERO;
    endcase
    return v;
  endfunction

  localparam logic [6:0] PWRUP_LOAD = 7'(PWRUP_CYCLES);

  // --------------------------------------------------------------------
  // Link side, serial clock domain
  // --------------------------------------------------------------------
  qd_link_type link_r;
  qd_link_type link_nxt;
  logic [31:0] word_r;
  logic link_clr;

  // Frame-sync high holds the counter and shift register cleared
  assign link_clr = sync_n_i | ~rstn_i;

  always_comb begin
    link_nxt = link_r;
    if (link_r.cnt != `QD_FULL_CNT) begin
      link_nxt.shift = {link_r.shift[30:0], din_i};
      link_nxt.cnt = link_r.cnt + 6'h01;
      if (link_r.cnt == `QD_LAST_BIT_CNT) begin
        link_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(negedge sclk_i or posedge link_clr) begin
    if (link_clr) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // Frame word outlives an early rise of frame-sync after bit 32
  always_ff @(negedge sclk_i) begin
    if (!sync_n_i && link_r.cnt == `QD_LAST_BIT_CNT) begin
      word_r <= {link_r.shift[30:0], din_i};
    end
  end

  // --------------------------------------------------------------------
  // Core side, system clock domain
  // --------------------------------------------------------------------
  qd_core_type core_r;
  qd_core_type core_nxt;

  always_comb begin
    logic frame_evt;
    logic load_dac_n_fall;
    logic clr_fall;
    logic [3:0] cmd;
    logic [3:0] sel;
    logic [3:0] pick;
    logic [1:0] pd;
    logic [15:0] data;
    frame_evt = 1'b0;
    load_dac_n_fall = 1'b0;
    clr_fall = 1'b0;
    cmd = word_r[`QD_CMD_MSB:`QD_CMD_LSB];
    sel = chan_mask(word_r[`QD_ADDR_MSB:`QD_ADDR_LSB]);
    pick = word_r[`QD_SEL_MSB:`QD_SEL_LSB];
    pd = word_r[`QD_PD_MSB:`QD_PD_LSB];
    data = word_r[`QD_DATA_MSB:`QD_DATA_LSB];
    core_nxt = core_r;

    // ------------------------------------------------------------------
    // Synchronisers for frame completion and pins
    // ------------------------------------------------------------------
    core_nxt.done_s1 = link_r.done;
    core_nxt.done_s2 = core_r.done_s1;
    core_nxt.done_s3 = core_r.done_s2;
    core_nxt.load_dac_n_s1 = load_dac_n_i;
    core_nxt.load_dac_n_s2 = core_r.load_dac_n_s1;
    core_nxt.load_dac_n_s3 = core_r.load_dac_n_s2;
    core_nxt.clr_s1 = clear_n_i;
    core_nxt.clr_s2 = core_r.clr_s1;
    core_nxt.clr_s3 = core_r.clr_s2;
    core_nxt.por_s1 = por_level_i;
    core_nxt.por_s2 = core_r.por_s1;
    frame_evt = core_r.done_s2 & ~core_r.done_s3;
    load_dac_n_fall = core_r.load_dac_n_s3 & ~core_r.load_dac_n_s2;
    clr_fall = core_r.clr_s3 & ~core_r.clr_s2;

    // ------------------------------------------------------------------
    // Power-up settling timers
    // ------------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      if (core_r.pu_cnt[i] != 7'h00) begin
        core_nxt.pu_cnt[i] = core_r.pu_cnt[i] - 7'h01;
      end
    end

    // ------------------------------------------------------------------
    // Reset sequence, pins and command execution
    // ------------------------------------------------------------------
    unique case (core_r.state)
      QD_ST_POR: begin
        // Pins and frames are not acted on here
        core_nxt.por_cnt = core_r.por_cnt + 2'h1;
        if (core_r.por_cnt == `QD_POR_WAIT_CYCLES - 2'h1) begin
          for (int i = 0; i < 4; i++) begin
            core_nxt.in_reg[i] = por_code(core_r.por_s2);
            core_nxt.dac_reg[i] = por_code(core_r.por_s2);
          end
          core_nxt.state = QD_ST_RUN;
        end
      end
      QD_ST_RUN: begin
        if (clr_fall) begin
          for (int i = 0; i < 4; i++) begin
            core_nxt.in_reg[i] = clr_value(core_r.clr_code);
            core_nxt.dac_reg[i] = clr_value(core_r.clr_code);
          end
        end else if (load_dac_n_fall) begin
          for (int i = 0; i < 4; i++) begin
            core_nxt.dac_reg[i] = core_r.in_reg[i];
          end
        end
        if (frame_evt) begin
          unique case (cmd)
            `QD_CMD_WR_IN: begin
              for (int i = 0; i < 4; i++) begin
                if (sel[i]) begin
                  core_nxt.in_reg[i] = data;
                  if (!core_r.load_dac_n_s2 || core_r.load_dac_n_mask[i]) begin
                    core_nxt.dac_reg[i] = data;
                  end
                end
              end
            end
            `QD_CMD_UPD: begin
              for (int i = 0; i < 4; i++) begin
                if (sel[i]) begin
                  core_nxt.dac_reg[i] = core_r.in_reg[i];
                end
              end
            end
            `QD_CMD_WR_UPD_ALL: begin
              for (int i = 0; i < 4; i++) begin
                if (sel[i]) begin
                  core_nxt.in_reg[i] = data;
                end
                core_nxt.dac_reg[i] = sel[i] ? data : core_r.in_reg[i];
              end
              if (sel == 4'h0) begin
                core_nxt.dac_reg = core_r.dac_reg;
              end
            end
            `QD_CMD_WR_UPD: begin
              for (int i = 0; i < 4; i++) begin
                if (sel[i]) begin
                  core_nxt.in_reg[i] = data;
                  core_nxt.dac_reg[i] = data;
                end
              end
            end
            `QD_CMD_POWER: begin
              for (int i = 0; i < 4; i++) begin
                if (pick[i]) begin
                  // DAC contents stay as they are on power-down
                  core_nxt.pmode[i] = pd;
                  if (pd == `QD_PM_NORMAL && core_r.pmode[i] != `QD_PM_NORMAL) begin
                    core_nxt.pu_cnt[i] = PWRUP_LOAD;
                    if (!core_r.load_dac_n_s2) begin
                      core_nxt.dac_reg[i] = core_r.in_reg[i];
                    end
                  end
                end
              end
            end
            `QD_CMD_CLR_CODE: begin
              core_nxt.clr_code = word_r[`QD_LOW2_MSB:`QD_LOW2_LSB];
            end
            `QD_CMD_LOAD_DAC_N_MASK: begin
              core_nxt.load_dac_n_mask = word_r[`QD_SEL_MSB:`QD_SEL_LSB];
            end
            `QD_CMD_RESET: begin
              core_nxt.state = QD_ST_POR;
              core_nxt.por_cnt = 2'h0;
              core_nxt.clr_code = `QD_CLR_CODE_RST;
              core_nxt.load_dac_n_mask = `QD_LOAD_DAC_N_MASK_RST;
              core_nxt.daisy_chain_enable = `QD_DAISY_CHAIN_ENABLE_RST;
              for (int i = 0; i < 4; i++) begin
                core_nxt.pmode[i] = `QD_PM_NORMAL;
                core_nxt.pu_cnt[i] = 7'h00;
              end
            end
            `QD_CMD_DAISY: begin
              core_nxt.daisy_chain_enable = word_r[`QD_LOW2_MSB:`QD_LOW2_LSB];
            end
            `QD_CMD_AUX: begin
              core_nxt.daisy_chain_enable = core_r.daisy_chain_enable;
            end
            default: begin
              core_nxt.daisy_chain_enable = core_r.daisy_chain_enable;
            end
          endcase
        end
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Core registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      core_r <= '0;
      core_r.state <= QD_ST_POR;
      core_r.daisy_chain_enable <= `QD_DAISY_CHAIN_ENABLE_RST;
      core_r.clr_code <= `QD_CLR_CODE_RST;
      core_r.load_dac_n_mask <= `QD_LOAD_DAC_N_MASK_RST;
      core_r.load_dac_n_s1 <= 1'b1;
      core_r.load_dac_n_s2 <= 1'b1;
      core_r.load_dac_n_s3 <= 1'b1;
      core_r.clr_s1 <= 1'b1;
      core_r.clr_s2 <= 1'b1;
      core_r.clr_s3 <= 1'b1;
    end else begin
      core_r <= core_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dac_code_o[16*i +: 16] = core_r.dac_reg[i];
      power_mode_o[2*i +: 2] = core_r.pmode[i];
      out_connected_o[i] = (core_r.pmode[i] == `QD_PM_NORMAL);
      out_ready_o[i] = out_connected_o[i] && (core_r.pu_cnt[i] == 7'h00) &&
                       (core_r.state == QD_ST_RUN);
    end
  end

  assign daisy_chain_enable_o = core_r.daisy_chain_enable;
  assign por_busy_o = (core_r.state == QD_ST_POR);

endmodule

`default_nettype wire

// ==== sim/qd_command_port_props.sv ====
`include "qd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module qd_command_port_props #(
  parameter int PWRUP_CYCLES = `QD_PWRUP_CYCLES
) (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Reset, active low
  input wire logic load_dac_n_i, // Load-DAC pin
  input wire logic por_level_i, // Power-on level select
  input wire logic [63:0] dac_code_o, // DAC registers
  input wire logic [7:0] power_mode_o, // Power modes
  input wire logic [3:0] out_connected_o, // Outputs connected
  input wire logic [3:0] out_ready_o, // Outputs ready
  input wire logic [1:0] daisy_chain_enable_o, // Daisy-chain setting
  input wire logic por_busy_o // Reset sequence running
);
  localparam int RDY_MIN = PWRUP_CYCLES - 2;
  localparam int RDY_MAX = PWRUP_CYCLES + 3;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  busy_no_ready_a: assert property (
    por_busy_o |-> out_ready_o == 4'h0) else $error("ready during reset");
  conn_by_mode_a: assert property (
    out_connected_o == {power_mode_o[7:6] == 2'h0, power_mode_o[5:4] == 2'h0,
    power_mode_o[3:2] == 2'h0, power_mode_o[1:0] == 2'h0}) else $error("connect vs mode");
  ready_conn_a: assert property (
    (out_ready_o & ~out_connected_o) == 4'h0) else $error("ready while disconnected");
  pd_keeps_code_a: assert property (
    $changed(power_mode_o) && load_dac_n_i && !por_busy_o && !$past(por_busy_o)
    |-> $stable(dac_code_o)) else $error("mode change altered code");
  pwrup_wait_a: assert property (
    $rose(out_connected_o[0]) && !por_busy_o && !$past(por_busy_o)
    |-> !out_ready_o[0] ##[RDY_MIN:RDY_MAX] out_ready_o[0]) else $error("power-up wait");
  por_length_a: assert property (
    $rose(rstn_i) |-> por_busy_o ##[2:4] !por_busy_o) else $error("reset sequence length");
  por_code_a: assert property (
    $fell(por_busy_o) |-> dac_code_o == {4{por_level_i ? `QD_CODE_MID : `QD_CODE_ZERO}})
    else $error("power-on code");
  busy_hold_a: assert property (
    por_busy_o ##1 por_busy_o |-> $stable(dac_code_o)) else $error("code moved in reset");
  cover property ($fell(por_busy_o));
  cover property ($rose(out_ready_o[0]));
  cover property ($changed(daisy_chain_enable_o));
endmodule
bind qd_command_port qd_command_port_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) qd_command_port_props_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .load_dac_n_i(load_dac_n_i), .por_level_i(por_level_i),
  .dac_code_o(dac_code_o), .power_mode_o(power_mode_o), .out_connected_o(out_connected_o),
  .out_ready_o(out_ready_o), .daisy_chain_enable_o(daisy_chain_enable_o),
  .por_busy_o(por_busy_o));
`default_nettype wire

// ==== sim/qd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module qd_host_model #(
  parameter int HALF_NS = 40
) (
  output logic sclk_o, // Serial clock, still between frames
  output logic sync_n_o, // Frame-sync
  output logic din_o // Serial data
);
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    din_o = 1'b0;
  end
  // ----
  // Frame of n bits, MSB first; short frames end early
  // ----
  task automatic frame(input logic [31:0] w, input int n);
    sync_n_o = 1'b1;
    #(HALF_NS);
    sync_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      din_o = w[31 - i];
      #(HALF_NS);
      sclk_o = 1'b0;
      #(HALF_NS);
      sclk_o = 1'b1;
    end
    din_o = ~din_o;
    if (n < 32) begin
      #(HALF_NS);
      sync_n_o = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/qd_command_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module qd_command_port_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic load_dac_n_i = 1'b1;
  logic clear_n_i = 1'b1;
  logic por_level_i = 1'b1;
  logic sclk, sync_n, din, por_busy_o;
  logic [63:0] dac_code_o;
  logic [7:0] power_mode_o;
  logic [3:0] out_connected_o, out_ready_o;
  logic [1:0] daisy_chain_enable_o;
  int fail_count = 0;
  int compares = 0;
  int in_m[4], dac_m[4], pm_m[4];
  int daisy_chain_enable_m, clr_m, mask_m, por_m, nb, r, ld_m;
  logic [31:0] w;
  logic [3:0] cmds[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hF};
  logic [3:0] adrs[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
  always #12.5 clk_i = ~clk_i;
  qd_command_port #(.PWRUP_CYCLES(4)) qd_command_port_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .sync_n_i(sync_n), .din_i(din),
    .load_dac_n_i(load_dac_n_i), .clear_n_i(clear_n_i), .por_level_i(por_level_i),
    .dac_code_o(dac_code_o), .power_mode_o(power_mode_o), .out_connected_o(out_connected_o),
    .out_ready_o(out_ready_o), .daisy_chain_enable_o(daisy_chain_enable_o),
    .por_busy_o(por_busy_o));
  qd_host_model host_i (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
  // ----
  // Reference model and comparison
  // ----
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_all();
    logic [3:0] cn;
    for (int i = 0; i < 4; i++) cn[i] = (pm_m[i] == 0);
    chk("dac_code", {dac_m[3][15:0], dac_m[2][15:0], dac_m[1][15:0], dac_m[0][15:0]},
      dac_code_o);
    chk("power_mode", 64'({pm_m[3][1:0], pm_m[2][1:0], pm_m[1][1:0], pm_m[0][1:0]}),
      64'(power_mode_o));
    chk("connected", 64'(cn), 64'(out_connected_o));
    chk("ready", 64'(cn), 64'(out_ready_o));
    chk("daisy_chain_enable", 64'(daisy_chain_enable_m[1:0]), 64'(daisy_chain_enable_o));
  endtask
  task automatic model(input logic [31:0] v);
    logic [3:0] s;
    int c;
    c = v[27:24];
    s = v[23:20] == 4'h0 ? 4'h1 : v[23:20] == 4'h1 ? 4'h2 : v[23:20] == 4'hF ? 4'hF : 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (c < 4 && s[i] && c != 1) in_m[i] = v[19:4];
      if (c < 4 && s[i] && (c == 1 || c == 3 || (c == 0 && (mask_m[i] || ld_m)))) dac_m[i] = in_m[i];
      if (c == 4 && v[i] && v[9:8] == 2'h0 && pm_m[i] != 0 && ld_m) dac_m[i] = in_m[i];
      if (c == 4 && v[i]) pm_m[i] = v[9:8];
    end
    if (c == 2 && s != 4'h0) dac_m = in_m;
    if (c == 5) clr_m = v[1:0];
    if (c == 6) mask_m = v[3:0];
    if (c == 8) daisy_chain_enable_m = v[1:0];
    if (c == 7) begin
      dac_m = '{default: por_m};
      in_m = '{default: por_m};
      pm_m = '{default: 0};
      daisy_chain_enable_m = 0;
      clr_m = 0;
      mask_m = 0;
    end
  endtask
  task automatic step(input logic [31:0] v, input int n);
    host_i.frame(v, n);
    if (n == 32) model(v);
    repeat (12) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // Stimulus
  // ----
  initial begin
    void'($urandom(32'h361C681B));
    por_m = 16'h8000;
    dac_m = '{default: por_m};
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    check_all;
    step({4'($urandom), 4'h3, 4'hF, 20'($urandom)}, 32);
    check_all;
    for (int k = 0; k < 40; k++) begin
      w = $urandom;
      w[27:24] = cmds[$urandom % 10];
      w[23:20] = adrs[$urandom % 5];
      nb = ($urandom % 6 == 0) ? 1 + $urandom % 31 : 32;
      step(w, nb);
      r = $urandom % 4;
      if (r < 2) begin
        if (r == 0) clear_n_i <= 1'b0;
        else load_dac_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        clear_n_i <= 1'b1;
        load_dac_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
          if (r == 0) in_m[i] = clr_m == 1 ? 16'h8000 : clr_m == 2 ? 16'hFFFF : 16'h0000;
          dac_m[i] = in_m[i];
        end
        repeat (6) @(posedge clk_i);
      end
      check_all;
    end
    // Load-DAC held low: synchronous writes and power-up from input register
    load_dac_n_i <= 1'b0;
    ld_m = 1;
    repeat (6) @(posedge clk_i);
    dac_m = in_m;
    step(32'h0400_010F, 32);
    check_all;
    step(32'h0001_2340, 32);
    check_all;
    step(32'h0400_000F, 32);
    check_all;
    load_dac_n_i <= 1'b1;
    ld_m = 0;
    repeat (6) @(posedge clk_i);
    step({8'h07, 24'h0}, 32);
    check_all;
    por_level_i <= 1'b0;
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    por_m = 0;
    model({8'h07, 24'h0});
    repeat (10) @(posedge clk_i);
    check_all;
    wrap_up;
  end
  initial begin
    #500000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
